// ===== rtl/bsfs_top.sv
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module bsfs_top
	import bsfs_pkg::*;
(
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                hv_not_rising_in,
	input  wire logic                over_temp_in,
	input  wire logic                external_hv_input,
	input  wire logic                boost_pulse_in,
	input  wire logic                inj_active_in,
	input  wire logic [HV_WIDTH-1:0] hv_level,
	output logic                     boost_run,
	output logic                     injection_allow,
	output logic                     irq
);

	// ------------------------------------------------------------------
	// Declarations.
	// ------------------------------------------------------------------
	bsfs_sense_if sense ();

	logic                   enable;
	logic [HV_WIDTH-1:0]    idle_voltage_setpoint;
	logic [HV_WIDTH-1:0]    injection_voltage_setpoint;
	logic [NUM_FAULTS-1:0]  fault;
	logic [NUM_FAULTS-1:0]  fault_event;
	logic [NUM_FAULTS-1:0]  fault_clear;
	logic [NUM_FAULTS-1:0]  irq_enable;
	logic [USAGE_WIDTH-1:0] usage;
	logic [TIMER_WIDTH-1:0] leak_timer;
	logic [TIMER_WIDTH-1:0] charge_timer;
	logic [HV_WIDTH-1:0]    hv_meta;
	logic [HV_WIDTH-1:0]    hv_sync;
	logic [HV_WIDTH-1:0]    target;
	logic                   leak_tick;
	logic                   shutdown;
	logic                   charge_fault;
	logic                   usage_overload_fault;
	logic                   over_temperature_fault;
	logic                   over_voltage_fault;
	bsfs_reg_state_t        state;
	bsfs_reg_state_t        next_state;
	logic [7:0]             aw_addr;
	logic                   aw_held;
	logic [31:0]            w_data;
	logic [3:0]             w_strb;
	logic                   w_held;
	logic                   wr_fire;

	// ------------------------------------------------------------------
	// Sensor input stage.
	// ------------------------------------------------------------------
	bsfs_sync u_sync
	(
		.aclk             (aclk),
		.aresetn          (aresetn),
		.hv_not_rising_in (hv_not_rising_in),
		.over_temp_in     (over_temp_in),
		.ext_hv_in        (external_hv_input),
		.boost_pulse_in   (boost_pulse_in),
		.inj_active_in    (inj_active_in),
		.sense            (sense.src)
	);

	// The voltage word changes slowly; a two-stage sample is adequate since
	// regulation tolerates one stale code for a cycle.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hv_meta <= '0;
			hv_sync <= '0;
		end
		else
		begin
			hv_meta <= hv_level;
			hv_sync <= hv_meta;
		end
	end

	// ------------------------------------------------------------------
	// Boost regulation.
	// ------------------------------------------------------------------

	// Any latched fault or a live external supply forces the boost off.
	assign shutdown = (|fault) | sense.ext_hv;
	assign target   = sense.inj_active ? injection_voltage_setpoint
	                                   : idle_voltage_setpoint;

	// Hysteresis-free bang-bang control: charge below target, hold at or above.
	always_comb
	begin
		next_state = state;
		case (state)
			BSFS_OFF:
				if (enable && !shutdown)
					next_state = BSFS_CHARGE;
			BSFS_CHARGE:
				if (!enable || shutdown)
					next_state = BSFS_OFF;
				else if (hv_sync >= target)
					next_state = BSFS_HOLD;
			BSFS_HOLD:
				if (!enable || shutdown)
					next_state = BSFS_OFF;
				else if (hv_sync < target)
					next_state = BSFS_CHARGE;
			default:
				next_state = BSFS_OFF;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state <= BSFS_OFF;
		else
			state <= next_state;
	end

	// Outputs come from flip-flops; injection is gated by faults too.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			boost_run       <= 1'b0;
			injection_allow <= 1'b0;
		end
		else
		begin
			boost_run       <= (next_state == BSFS_CHARGE);
			injection_allow <= ~(|fault) & ~(|fault_event);
		end
	end

	// ------------------------------------------------------------------
	// Usage integrator.
	// ------------------------------------------------------------------
	assign leak_tick = (leak_timer == TIMER_WIDTH'(LEAK_CYCLES - 1));

	always_ff @(posedge aclk)
	begin
		if (!aresetn || leak_tick)
			leak_timer <= '0;
		else
			leak_timer <= leak_timer + 1'b1;
	end

	// Up and down in the same cycle cancel; the count saturates at both ends.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			usage <= '0;
		else if (sense.boost_pulse && !leak_tick && usage != '1)
			usage <= usage + USAGE_ONE;
		else if (leak_tick && !sense.boost_pulse && usage != '0)
			usage <= usage - USAGE_ONE;
	end

	// ------------------------------------------------------------------
	// Charge watchdog: a not-rising indication only counts while charging.
	// ------------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn || state != BSFS_CHARGE || !sense.hv_not_rising)
			charge_timer <= '0;
		else if (charge_timer != TIMER_WIDTH'(CHARGE_WIN_CYCLES))
			charge_timer <= charge_timer + 1'b1;
	end

	// ------------------------------------------------------------------
	// Fault flags: each its own sticky bit; set wins over clear.
	// ------------------------------------------------------------------
	assign fault_event[FLT_CHARGE_BIT]   = (charge_timer == TIMER_WIDTH'(CHARGE_WIN_CYCLES));
	assign fault_event[FLT_OVERLOAD_BIT] = (usage >= USAGE_LIMIT);
	assign fault_event[FLT_TEMP_BIT]     = sense.over_temp;
	assign fault_event[FLT_OVERVOLT_BIT] = (hv_sync > OVERVOLT_LIMIT);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			fault <= '0;
		else
			fault <= fault_event | (fault & ~fault_clear);
	end

	assign charge_fault           = fault[FLT_CHARGE_BIT];
	assign usage_overload_fault   = fault[FLT_OVERLOAD_BIT];
	assign over_temperature_fault = fault[FLT_TEMP_BIT];
	assign over_voltage_fault     = fault[FLT_OVERVOLT_BIT];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |(fault & irq_enable);
	end

	// ------------------------------------------------------------------
	// AXI4-Lite write path.
	// ------------------------------------------------------------------
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	// Address and data are latched independently and in either order.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			else if (wr_fire)
				aw_held <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			else if (wr_fire)
				w_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			case (aw_addr)
				ADDR_CTRL, ADDR_IDLE_SP, ADDR_INJ_SP, ADDR_CLEAR, ADDR_IRQ_EN:
					s_axi_bresp <= RESP_OKAY;
				default:
					s_axi_bresp <= RESP_SLVERR;
			endcase
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Software registers; the clear register is a one-cycle strobe.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			enable                     <= 1'b0;
			idle_voltage_setpoint      <= IDLE_SP_RESET;
			injection_voltage_setpoint <= INJ_SP_RESET;
			irq_enable                 <= '0;
			fault_clear                <= '0;
		end
		else
		begin
			fault_clear <= '0;
			if (wr_fire && w_strb[0])
			begin
				case (aw_addr)
					ADDR_CTRL:    enable                     <= w_data[CTRL_ENABLE_BIT];
					ADDR_IDLE_SP: idle_voltage_setpoint      <= w_data[HV_WIDTH-1:0];
					ADDR_INJ_SP:  injection_voltage_setpoint <= w_data[HV_WIDTH-1:0];
					ADDR_CLEAR:   fault_clear                <= w_data[NUM_FAULTS-1:0];
					ADDR_IRQ_EN:  irq_enable                 <= w_data[NUM_FAULTS-1:0];
					default:      ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read path.
	// ------------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_arready <= 1'b0;
		else
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			s_axi_rdata  <= '0;
			case (s_axi_araddr)
				ADDR_CTRL:     s_axi_rdata[CTRL_ENABLE_BIT]  <= enable;
				ADDR_IDLE_SP:  s_axi_rdata[HV_WIDTH-1:0]     <= idle_voltage_setpoint;
				ADDR_INJ_SP:   s_axi_rdata[HV_WIDTH-1:0]     <= injection_voltage_setpoint;
				ADDR_STATUS:   s_axi_rdata[NUM_FAULTS-1:0]   <= {over_voltage_fault, over_temperature_fault,
				                                                 usage_overload_fault, charge_fault};
				ADDR_CLEAR:    s_axi_rdata                   <= '0;
				ADDR_IRQ_EN:   s_axi_rdata[NUM_FAULTS-1:0]   <= irq_enable;
				ADDR_USAGE:    s_axi_rdata[USAGE_WIDTH-1:0]  <= usage;
				ADDR_HV_LEVEL: s_axi_rdata[HV_WIDTH-1:0]     <= hv_sync;
				ADDR_STATE:
				begin
					s_axi_rdata[ST_BOOST_BIT] <= (state == BSFS_CHARGE);
					s_axi_rdata[ST_EXT_BIT]   <= sense.ext_hv;
					s_axi_rdata[ST_SHUT_BIT]  <= shutdown;
					s_axi_rdata[ST_INJ_BIT]   <= sense.inj_active;
				end
				default:       s_axi_rresp <= RESP_SLVERR;
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule

// ===== shared/bsfs_pkg.sv
package bsfs_pkg;

	// ------------------------------------------------------------------
	// Register map (byte addresses, one aligned 32-bit word each).
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_IDLE_SP   = 8'h04;
	localparam logic [7:0] ADDR_INJ_SP    = 8'h08;
	localparam logic [7:0] ADDR_STATUS    = 8'h0C;
	localparam logic [7:0] ADDR_CLEAR     = 8'h10;
	localparam logic [7:0] ADDR_IRQ_EN    = 8'h14;
	localparam logic [7:0] ADDR_USAGE     = 8'h18;
	localparam logic [7:0] ADDR_HV_LEVEL  = 8'h1C;
	localparam logic [7:0] ADDR_STATE     = 8'h20;

	// ------------------------------------------------------------------
	// Field positions.
	// ------------------------------------------------------------------
	localparam int CTRL_ENABLE_BIT  = 0;
	localparam int FLT_CHARGE_BIT   = 0;
	localparam int FLT_OVERLOAD_BIT = 1;
	localparam int FLT_TEMP_BIT     = 2;
	localparam int FLT_OVERVOLT_BIT = 3;
	localparam int NUM_FAULTS       = 4;
	localparam int HV_WIDTH         = 8;
	localparam int USAGE_WIDTH      = 16;
	localparam int ST_BOOST_BIT     = 0;
	localparam int ST_EXT_BIT       = 1;
	localparam int ST_SHUT_BIT      = 2;
	localparam int ST_INJ_BIT       = 3;

	// ------------------------------------------------------------------
	// Reset values and thresholds.
	// ------------------------------------------------------------------
	localparam logic [HV_WIDTH-1:0]    IDLE_SP_RESET  = 8'h64;
	localparam logic [HV_WIDTH-1:0]    INJ_SP_RESET   = 8'h64;
	localparam logic [HV_WIDTH-1:0]    OVERVOLT_LIMIT = 8'h9B;
	localparam logic [USAGE_WIDTH-1:0] USAGE_LIMIT    = 16'hEA60;
	localparam logic [USAGE_WIDTH-1:0] USAGE_ONE      = 16'h0001;

	// ------------------------------------------------------------------
	// Timing: leak interval and charge-watchdog window.
	// ------------------------------------------------------------------
	localparam int CLK_MHZ           = 200;
	localparam int LEAK_PERIOD_US    = 10;
	localparam int LEAK_CYCLES       = LEAK_PERIOD_US * CLK_MHZ;
	localparam int CHARGE_WINDOW_US  = 5000;
	localparam int CHARGE_WIN_CYCLES = CHARGE_WINDOW_US * CLK_MHZ;
	localparam int TIMER_WIDTH       = 24;

	// ------------------------------------------------------------------
	// AXI4-Lite responses.
	// ------------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {BSFS_OFF, BSFS_CHARGE, BSFS_HOLD} bsfs_reg_state_t;

endpackage

// ===== shared/bsfs_sense_if.sv
`timescale 1ns/100ps
// Synchronised sensor indications handed from the input stage to the supervisor.
interface bsfs_sense_if;
	logic hv_not_rising;
	logic over_temp;
	logic ext_hv;
	logic boost_pulse;
	logic inj_active;
	modport src (output hv_not_rising, output over_temp, output ext_hv, output boost_pulse, output inj_active);
	modport dst (input hv_not_rising, input over_temp, input ext_hv, input boost_pulse, input inj_active);
endinterface

// ===== rtl/bsfs_sync.sv
`timescale 1ns/100ps
module bsfs_sync
	import bsfs_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic hv_not_rising_in,
	input  wire logic over_temp_in,
	input  wire logic ext_hv_in,
	input  wire logic boost_pulse_in,
	input  wire logic inj_active_in,
	bsfs_sense_if.src sense
);

	// ------------------------------------------------------------------
	// Two-stage synchronisers; only stage two is read downstream.
	// ------------------------------------------------------------------
	logic [4:0] meta;
	logic [4:0] stable;
	logic       pulse_prev;

	// Both stages clear on reset so no stale sensor level leaks out.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta   <= 5'h00;
			stable <= 5'h00;
		end
		else
		begin
			meta   <= {inj_active_in, boost_pulse_in, ext_hv_in, over_temp_in, hv_not_rising_in};
			stable <= meta;
		end
	end

	// Edge detect on the synchronised boost pulse so each pulse counts once.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pulse_prev <= 1'b0;
		else
			pulse_prev <= stable[3];
	end

	assign sense.hv_not_rising = stable[0];
	assign sense.over_temp     = stable[1];
	assign sense.ext_hv        = stable[2];
	assign sense.boost_pulse   = stable[3] & ~pulse_prev;
	assign sense.inj_active    = stable[4];

endmodule

// ===== bench/bsfs_properties.sv
`timescale 1ns/100ps
module bsfs_properties
	import bsfs_pkg::*;
(
	input wire logic                aclk,
	input wire logic                aresetn,
	input wire logic                s_axi_awvalid,
	input wire logic                s_axi_awready,
	input wire logic                s_axi_wvalid,
	input wire logic                s_axi_wready,
	input wire logic [1:0]          s_axi_bresp,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_bready,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic [31:0]         s_axi_rdata,
	input wire logic                s_axi_rvalid,
	input wire logic                s_axi_rready,
	input wire logic                over_temp_in,
	input wire logic                external_hv_input,
	input wire logic [HV_WIDTH-1:0] hv_level,
	input wire logic                boost_run,
	input wire logic                injection_allow
);
	// ------------------------------------------------------------------
	// Bus timing and supervisor shutdown checks.
	// ------------------------------------------------------------------
	// Sensor effects reach the outputs four cycles after a pin change, so six cycles leave margin.
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing one cycle after address taken");
	a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer missing two cycles after address and data taken");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before it was accepted");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before it was accepted");
	a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("new read address accepted while data is pending");
	a_ext_shuts_boost: assert property (external_hv_input [*6] |-> !boost_run)
		else $error("boost runs while external supply is present");
	a_temp_shutdown: assert property (over_temp_in [*6] |-> !boost_run && !injection_allow)
		else $error("boost or injection still allowed while hot");
	a_overvolt_shutdown: assert property ((hv_level > OVERVOLT_LIMIT) [*6] |-> !boost_run && !injection_allow)
		else $error("boost or injection still allowed above voltage limit");
	a_fault_sticky: assert property ($fell(injection_allow) |=> !injection_allow [*4])
		else $error("injection allowed again right after a fault");
endmodule

bind bsfs_top bsfs_properties chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .over_temp_in, .external_hv_input, .hv_level, .boost_run, .injection_allow);

// ===== bench/bsfs_host_model.sv
`timescale 1ns/100ps
module bsfs_host_model
	import bsfs_pkg::*;
(
	input  wire logic        aclk,
	output logic [7:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [7:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	// ------------------------------------------------------------------
	// Host control logic on the register bus.
	// ------------------------------------------------------------------
	// A slow host delays its response ready, which exercises the hold of each answer.
	logic slow = 1'b0;

	initial
	begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end

	// Any writable register, the enable included, may be written at any time; faults are cleared here too.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		int k;
		k = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= !slow;
		do
		begin
			@(posedge aclk);
			k++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			// Raise ready only once so the closing release is its only change at that edge.
			if (k == 3 && !s_axi_bready)
				s_axi_bready <= 1'b1;
		end
		while (!(s_axi_bvalid === 1'b1 && s_axi_bready));
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		int k;
		k = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !slow;
		do
		begin
			@(posedge aclk);
			k++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (k == 3 && !s_axi_rready)
				s_axi_rready <= 1'b1;
		end
		while (!(s_axi_rvalid === 1'b1 && s_axi_rready));
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// ===== bench/boost_supply_fault_supervisor_bench.sv
`timescale 1ns/100ps
module boost_supply_fault_supervisor_bench
	import bsfs_pkg::*;
;
	// ------------------------------------------------------------------
	// Signals, design and host.
	// ------------------------------------------------------------------
	logic        aclk, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, hv_level = 8'h00, sp_i, sp_j;
	logic [31:0] s_axi_wdata, s_axi_rdata, sd = 32'h5D39, n, u1, u2;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, boost_run, injection_allow, irq;
	logic        hv_not_rising_in = 1'b0, over_temp_in = 1'b0, external_hv_input = 1'b0;
	logic        boost_pulse_in = 1'b0, inj_active_in = 1'b0, en = 1'b0, flt = 1'b0;
	int          fails = 0, cmp_count = 0, cycles = 0;
	logic [7:0]  ra [8] = '{ADDR_CTRL, ADDR_IDLE_SP, ADDR_INJ_SP, ADDR_STATUS, ADDR_CLEAR, ADDR_IRQ_EN, ADDR_USAGE, 8'h40};
	logic [31:0] rv [8] = '{32'h0, 32'h64, 32'h64, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

	bsfs_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hv_not_rising_in, .over_temp_in,
		.external_hv_input, .boost_pulse_in, .inj_active_in, .hv_level, .boost_run, .injection_allow, .irq);
	bsfs_host_model host_u (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	// ------------------------------------------------------------------
	// Clock, timeout, expectations and compares.
	// ------------------------------------------------------------------
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// The whole run needs about 4,400 cycles; the ceiling at 20,000 cycles only ends a hang.
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			conclude();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	// The boost charges only when enabled, unfaulted, without external supply and below the active target.
	function automatic logic exp_boost(input logic [7:0] hv, input logic inj, input logic ext);
		return en && !ext && !flt && (hv < (inj ? sp_j : sp_i));
	endfunction

	task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_bit(input string name, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		host_u.rd(a, u1, r);
		chk_word("read data", e, u1);
		chk_word("read response", {30'h0, er}, {30'h0, r});
	endtask

	task automatic wrchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		host_u.wr(a, d, r);
		chk_word("write response", {30'h0, er}, {30'h0, r});
	endtask

	// Inputs change together and are given eight cycles to pass the synchronisers.
	task automatic drive(input logic [7:0] hv, input logic inj, input logic ext);
		@(posedge aclk);
		hv_level <= hv;
		inj_active_in <= inj;
		external_hv_input <= ext;
		repeat (8) @(posedge aclk);
		chk_bit("boost_run", exp_boost(hv, inj, ext), boost_run);
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		host_u.slow = 1'b1;
		for (int i = 0; i < 8; i++)
			rdchk(ra[i], rv[i], (i == 7) ? RESP_SLVERR : RESP_OKAY);
		// The first writes also answer a slow host, so the held write response is exercised.
		wrchk(ADDR_STATUS, 32'hF, RESP_SLVERR);
		wrchk(8'h44, 32'h1, RESP_SLVERR);
		host_u.slow = 1'b0;
		sd = xs(sd);
		sp_i = 8'h40 + {2'h0, sd[5:0]};
		sp_j = sp_i - 8'h20;
		hv_not_rising_in <= sd[6];
		wrchk(ADDR_IDLE_SP, {24'h0, sp_i}, RESP_OKAY);
		wrchk(ADDR_INJ_SP, {24'h0, sp_j}, RESP_OKAY);
		drive(sp_i - 8'h01, 1'b0, 1'b0);
		en = 1'b1;
		wrchk(ADDR_CTRL, 32'h1, RESP_OKAY);
		drive(sp_i - 8'h01, 1'b0, 1'b0);
		drive(sp_i, 1'b0, 1'b0);
		drive(sp_i - 8'h10, 1'b0, 1'b0);
		drive(sp_i - 8'h10, 1'b1, 1'b0);
		drive(sp_j - 8'h01, 1'b1, 1'b0);
		drive(sp_i - 8'h10, 1'b0, 1'b0);
		drive(sp_i - 8'h10, 1'b0, 1'b1);
		rdchk(ADDR_STATE, 32'h6, RESP_OKAY);
		drive(sp_i - 8'h10, 1'b0, 1'b0);
		en = 1'b0;
		wrchk(ADDR_CTRL, 32'h0, RESP_OKAY);
		drive(sp_i - 8'h10, 1'b0, 1'b0);
		en = 1'b1;
		wrchk(ADDR_CTRL, 32'h1, RESP_OKAY);
		wrchk(ADDR_IRQ_EN, 32'hC, RESP_OKAY);
		over_temp_in <= 1'b1;
		flt = 1'b1;
		drive(8'h9C, 1'b0, 1'b0);
		chk_bit("injection_allow", 1'b0, injection_allow);
		chk_bit("irq", 1'b1, irq);
		rdchk(ADDR_STATUS, 32'hC, RESP_OKAY);
		rdchk(ADDR_HV_LEVEL, 32'h9C, RESP_OKAY);
		wrchk(ADDR_CLEAR, 32'hF, RESP_OKAY);
		rdchk(ADDR_STATUS, 32'hC, RESP_OKAY);
		over_temp_in <= 1'b0;
		drive(sp_i - 8'h01, 1'b0, 1'b0);
		rdchk(ADDR_STATUS, 32'hC, RESP_OKAY);
		wrchk(ADDR_IRQ_EN, 32'h0, RESP_OKAY);
		repeat (4) @(posedge aclk);
		chk_bit("irq", 1'b0, irq);
		wrchk(ADDR_CLEAR, 32'h4, RESP_OKAY);
		rdchk(ADDR_STATUS, 32'h8, RESP_OKAY);
		wrchk(ADDR_IRQ_EN, 32'hC, RESP_OKAY);
		repeat (4) @(posedge aclk);
		chk_bit("irq", 1'b1, irq);
		wrchk(ADDR_CLEAR, 32'h8, RESP_OKAY);
		flt = 1'b0;
		drive(sp_i - 8'h01, 1'b0, 1'b0);
		chk_bit("irq", 1'b0, irq);
		chk_bit("injection_allow", 1'b1, injection_allow);
		sd = xs(sd);
		n = 32'h3 + {28'h0, sd[3:0]};
		repeat (n)
		begin
			@(posedge aclk);
			boost_pulse_in <= 1'b1;
			repeat (3) @(posedge aclk);
			boost_pulse_in <= 1'b0;
			repeat (2) @(posedge aclk);
		end
		repeat (8) @(posedge aclk);
		host_u.rd(ADDR_USAGE, u1, r);
		chk_bit("usage count", 1'b1, (u1 === n) || (u1 === n - 32'h1));
		// Two reads 4000 cycles apart must straddle exactly two leak ticks.
		repeat (3997) @(posedge aclk);
		host_u.rd(ADDR_USAGE, u2, r);
		chk_word("usage leak", u1 - 32'h2, u2);
		conclude();
	end
endmodule
